//--- hw/tmr_pkg.sv
// constants, register map and state layout of the timer block control logic
// assumes one bus clock that also serves as the peripheral clock for the prescaler
package tmr_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_CH    = 3;
  localparam int CTR_WIDTH = 16;

  // ----------------------------------------------------------------
  // register offsets (channel registers repeat every CH_STRIDE)
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_STRIDE  = 8'h40;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_IEN    = 8'h24;
  localparam logic [7:0] OFF_IDIS   = 8'h28;
  localparam logic [7:0] OFF_MASK   = 8'h2C;
  localparam logic [7:0] OFF_CMD    = 8'hC0;
  localparam logic [7:0] OFF_ROUTE  = 8'hC4;
  localparam logic [7:0] OFF_FEAT   = 8'hF8;
  localparam logic [7:0] OFF_VER    = 8'hFC;

  // ----------------------------------------------------------------
  // field positions and fixed values
  // ----------------------------------------------------------------
  localparam int CMD_SYNC_BIT    = 0;
  localparam int ROUTE_LINE0_LSB = 0;
  localparam int ROUTE_LINE1_LSB = 2;
  localparam int ROUTE_LINE2_LSB = 4;
  localparam int FEAT_UPDN_BIT   = 8;
  localparam int FEAT_BRIDGE_BIT = 9;
  localparam logic [31:0] FEAT_VALUE = 32'h0000_0310;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

  // ----------------------------------------------------------------
  // counter clock sources and routing choices
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_SLOW_OSC = 3'h0,
    SRC_DIV2     = 3'h1,
    SRC_DIV8     = 3'h2,
    SRC_DIV32    = 3'h3,
    SRC_DIV128   = 3'h4,
    SRC_LINE0    = 3'h5,
    SRC_LINE1    = 3'h6,
    SRC_LINE2    = 3'h7
  } clk_src_e;

  localparam logic [1:0] ROUTE_PIN  = 2'h0;
  localparam logic [1:0] ROUTE_NONE = 2'h1;
  localparam logic [1:0] ROUTE_A    = 2'h2;
  localparam logic [1:0] ROUTE_B    = 2'h3;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
  } ahb_req_s;

  typedef struct packed {
    logic [NUM_CH-1:0][7:0] mask;
    logic [NUM_CH-1:0][7:0] status;
    logic [5:0]             route;
    logic [6:0]             presc;
    logic [2:0]             pin_s1;
    logic [2:0]             pin_s2;
    logic                   osc_s1;
    logic                   osc_s2;
    logic                   osc_s3;
    logic [2:0]             line_prev;
    logic                   dp_valid;
    logic                   dp_write;
    logic [7:0]             dp_addr;
    logic [NUM_CH-1:0]      trig;
    logic [NUM_CH-1:0]      tick;
    logic [31:0]            rdata;
  } state_s;

endpackage : tmr_pkg

//--- hw/timer_block_control_regs.sv
// block-level control of a three-channel timer: masks, status, sync, clock routing, ids
// assumes an AHB-Lite master on sys_clk_i and channel logic on the same clock
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - writing one to an enable strobe bit sets that channel mask bit
// - writing one to a disable strobe bit clears that channel mask bit
// - mask register is read-only, resets to zero, one enables the source
// - command bit 0 written one triggers all three channels together; zero ignored
// - line two selector: pin two, none, channel 0 A, channel 1 A
// - line one selector: pin one, none, channel 0 A, channel 2 A
// - line zero selector: pin zero, none, channel 1 A, channel 2 A
// - capability bit 9 reads one for the bridge kind
// - capability bit 8 reads one; whole word is fixed
// - capability low byte reports the 16-bit counter width
// - revision word holds 12-bit version and reserved variant, no effect
// - each channel picks slow oscillator, bus clock by 2/8/32/128, or a line
// - one instance holds exactly three channels
// - register interface shares the bus clock with all channel logic
// - reading a channel status clears its flags and derived interrupt
module timer_block_control_regs #(
  parameter int          NUM_CH      = 3,
  parameter logic [11:0] VERSION_NUM = 12'h101, // arbitrary value
  parameter logic [3:0]  VARIANT_NUM = 4'h0     // arbitrary value
) (
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   hsel_i,
  input  wire tmr_pkg::ahb_req_s      ahb_req_i,
  input  wire logic [31:0]            hwdata_i,
  input  wire logic                   hready_i,
  output logic                        hreadyout_o,
  output logic                        hresp_o,
  output logic [31:0]                 hrdata_o,
  input  wire logic [NUM_CH-1:0][7:0] chan_event_i,
  input  wire logic [NUM_CH-1:0]      chan_out_a_i,
  input  wire logic [NUM_CH-1:0][2:0] chan_clk_sel_i,
  input  wire logic [2:0]             pin_clk_i,
  input  wire logic                   slow_osc_i,
  output logic [NUM_CH-1:0]           sw_trigger_o,
  output logic [NUM_CH-1:0]           chan_tick_o,
  output logic [NUM_CH-1:0]           chan_irq_o,
  output logic                        irq_o
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  // routing and decode are hard-wired for three channels
  if (NUM_CH != tmr_pkg::NUM_CH)
  begin : g_bad_ch
    $error("NUM_CH must be 3");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  tmr_pkg::state_s st_q;
  tmr_pkg::state_s st_d;

  logic              acc;
  logic              rd_acc;
  logic [7:0]        a_addr;
  logic              wr_cmd;
  logic              wr_route;
  logic [NUM_CH-1:0] wr_ien;
  logic [NUM_CH-1:0] wr_idis;
  logic [NUM_CH-1:0] rd_stat;
  logic [2:0]        line;
  logic [7:0]        src_tick;

  function automatic logic route_pick(input logic [1:0] s,
                                      input logic       pin,
                                      input logic       a,
                                      input logic       b);
    logic r;
    r = 1'b0;
    case (s)
      tmr_pkg::ROUTE_PIN:  r = pin;
      tmr_pkg::ROUTE_NONE: r = 1'b0;
      tmr_pkg::ROUTE_A:    r = a;
      tmr_pkg::ROUTE_B:    r = b;
      default:             r = 1'b0;
    endcase
    return r;
  endfunction : route_pick

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // zero wait states: read data is fetched at the address phase
  assign acc    = hsel_i && hready_i && ahb_req_i.htrans == tmr_pkg::HTRANS_NONSEQ;
  assign rd_acc = acc && !ahb_req_i.hwrite;
  assign a_addr = ahb_req_i.haddr[7:0];
  assign wr_cmd   = st_q.dp_valid && st_q.dp_write && st_q.dp_addr == tmr_pkg::OFF_CMD;
  assign wr_route = st_q.dp_valid && st_q.dp_write && st_q.dp_addr == tmr_pkg::OFF_ROUTE;

  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_dec
    localparam logic [7:0] BASE = 8'(c * tmr_pkg::CH_STRIDE);
    assign wr_ien[c]  = st_q.dp_valid && st_q.dp_write && st_q.dp_addr == BASE + tmr_pkg::OFF_IEN;
    assign wr_idis[c] = st_q.dp_valid && st_q.dp_write && st_q.dp_addr == BASE + tmr_pkg::OFF_IDIS;
    assign rd_stat[c] = rd_acc && a_addr == BASE + tmr_pkg::OFF_STATUS;
  end

  // ----------------------------------------------------------------
  // clock routing and sources
  // ----------------------------------------------------------------
  assign line[0] = route_pick(st_q.route[tmr_pkg::ROUTE_LINE0_LSB +: 2],
                              st_q.pin_s2[0], chan_out_a_i[1], chan_out_a_i[2]);
  assign line[1] = route_pick(st_q.route[tmr_pkg::ROUTE_LINE1_LSB +: 2],
                              st_q.pin_s2[1], chan_out_a_i[0], chan_out_a_i[2]);
  assign line[2] = route_pick(st_q.route[tmr_pkg::ROUTE_LINE2_LSB +: 2],
                              st_q.pin_s2[2], chan_out_a_i[0], chan_out_a_i[1]);

  // sources become one-cycle ticks so channels never run on a derived clock
  always_comb
  begin
    src_tick                        = 8'h00;
    src_tick[tmr_pkg::SRC_SLOW_OSC] = st_q.osc_s2 && !st_q.osc_s3;
    src_tick[tmr_pkg::SRC_DIV2]     = st_q.presc[0];
    src_tick[tmr_pkg::SRC_DIV8]     = &st_q.presc[2:0];
    src_tick[tmr_pkg::SRC_DIV32]    = &st_q.presc[4:0];
    src_tick[tmr_pkg::SRC_DIV128]   = &st_q.presc[6:0];
    src_tick[tmr_pkg::SRC_LINE0]    = line[0] && !st_q.line_prev[0];
    src_tick[tmr_pkg::SRC_LINE1]    = line[1] && !st_q.line_prev[1];
    src_tick[tmr_pkg::SRC_LINE2]    = line[2] && !st_q.line_prev[2];
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d           = st_q;
    st_d.pin_s1    = pin_clk_i;
    st_d.pin_s2    = st_q.pin_s1;
    st_d.osc_s1    = slow_osc_i;
    st_d.osc_s2    = st_q.osc_s1;
    st_d.osc_s3    = st_q.osc_s2;
    st_d.line_prev = line;
    st_d.presc     = st_q.presc + 7'h01;
    st_d.dp_valid  = acc;
    st_d.dp_write  = ahb_req_i.hwrite;
    st_d.dp_addr   = a_addr;
    st_d.trig      = '0;
    st_d.rdata     = tmr_pkg::RESET_WORD;
    for (int c = 0; c < NUM_CH; c++)
    begin
      st_d.tick[c] = src_tick[chan_clk_sel_i[c]];
      if (wr_ien[c])
      begin
        st_d.mask[c] = st_q.mask[c] | hwdata_i[7:0];
      end
      if (wr_idis[c])
      begin
        st_d.mask[c] = st_q.mask[c] & ~hwdata_i[7:0];
      end
      // an event in the clearing cycle survives the read
      st_d.status[c] = (rd_stat[c] ? 8'h00 : st_q.status[c]) | chan_event_i[c];
    end
    if (wr_cmd && hwdata_i[tmr_pkg::CMD_SYNC_BIT])
    begin
      st_d.trig = '1;
    end
    if (wr_route)
    begin
      st_d.route = hwdata_i[5:0];
    end
    if (rd_acc)
    begin
      case (a_addr)
        tmr_pkg::OFF_ROUTE: st_d.rdata = {26'h0000000, st_q.route};
        tmr_pkg::OFF_FEAT:  st_d.rdata = tmr_pkg::FEAT_VALUE;
        tmr_pkg::OFF_VER:   st_d.rdata = {12'h000, VARIANT_NUM, 4'h0, VERSION_NUM};
        default:
        begin
          for (int c = 0; c < NUM_CH; c++)
          begin
            if (a_addr == 8'(c * tmr_pkg::CH_STRIDE) + tmr_pkg::OFF_STATUS)
            begin
              st_d.rdata = {24'h000000, st_q.status[c]};
            end
            if (a_addr == 8'(c * tmr_pkg::CH_STRIDE) + tmr_pkg::OFF_MASK)
            begin
              st_d.rdata = {24'h000000, st_q.mask[c]};
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // the bus clock is this block's only clock
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hreadyout_o  = 1'b1;
  assign hresp_o      = 1'b0;
  assign hrdata_o     = st_q.rdata;
  assign sw_trigger_o = st_q.trig;
  assign chan_tick_o  = st_q.tick;

  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_irq
    assign chan_irq_o[c] = |(st_q.status[c] & st_q.mask[c]);
  end
  assign irq_o = |chan_irq_o;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_ien_sets_mask: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    wr_ien[0] |=> (st_q.mask[0] & $past(hwdata_i[7:0])) == $past(hwdata_i[7:0]))
    else $error("enable strobe did not set mask");

  a_idis_clears_mask: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    wr_idis[1] |=> (st_q.mask[1] & $past(hwdata_i[7:0])) == 8'h00)
    else $error("disable strobe did not clear mask");

  a_mask_reset_zero: assert property (
    @(posedge sys_clk_i)
    rst_i |=> st_q.mask == '0 && !irq_o)
    else $error("mask not zero after reset");

  a_sync_all_chan: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    wr_cmd |=> sw_trigger_o == {NUM_CH{$past(hwdata_i[tmr_pkg::CMD_SYNC_BIT])}} ##1 (sw_trigger_o == '0 || $past(wr_cmd)))
    else $error("sync trigger wrong");

  a_line2_route: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    st_q.route[5:4] == tmr_pkg::ROUTE_B |-> line[2] == chan_out_a_i[1])
    else $error("line two routing wrong");

  a_line1_route: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    st_q.route[3:2] == tmr_pkg::ROUTE_NONE |-> !line[1])
    else $error("line one routing wrong");

  a_line0_route: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    st_q.route[1:0] == tmr_pkg::ROUTE_A |-> line[0] == chan_out_a_i[1])
    else $error("line zero routing wrong");

  a_bridge_bit: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    rd_acc && a_addr == tmr_pkg::OFF_FEAT |=> hrdata_o[tmr_pkg::FEAT_BRIDGE_BIT])
    else $error("bridge bit not one");

  a_feature_word: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    rd_acc && a_addr == tmr_pkg::OFF_FEAT |=> hrdata_o == 32'h0000_0310)
    else $error("feature word wrong");

  a_width_field: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    rd_acc && a_addr == tmr_pkg::OFF_FEAT |=> hrdata_o[7:0] == 8'h10)
    else $error("counter width wrong");

  a_version_word: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    rd_acc && a_addr == tmr_pkg::OFF_VER |=> hrdata_o[31:20] == 12'h000 && hrdata_o[11:0] == VERSION_NUM)
    else $error("version word wrong");

  a_div2_tick: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (chan_clk_sel_i[0] == tmr_pkg::SRC_DIV2) [*3] |-> chan_tick_o[0] != $past(chan_tick_o[0]))
    else $error("div2 tick not alternating");

  a_status_rd_clear: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    rd_stat[0] && chan_event_i[0] == 8'h00 |=> st_q.status[0] == 8'h00 && !chan_irq_o[0])
    else $error("status read did not clear");

  a_irq_level: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    chan_event_i[2] != 8'h00 && !rd_stat[2] |=> chan_irq_o[2] == |($past(chan_event_i[2]) & st_q.mask[2]) || chan_irq_o[2])
    else $error("channel interrupt level wrong");

endmodule : timer_block_control_regs

`default_nettype wire

//--- sim/tb_timer_block_control_regs.sv
// self-checking bench for the timer block control logic
// assumes tmr_pkg is compiled first; the bench drives every input of the block directly except hready_i, which is fed back from hreadyout_o
`timescale 1ns/1ps
`default_nettype none
module tb_timer_block_control_regs;
  localparam logic [11:0] VER_NUM = 12'h101; // arbitrary value
  localparam logic [3:0]  VAR_NUM = 4'h5;    // arbitrary value, non-zero so a misplaced field shows
  logic              sys_clk  = 1'b0;
  logic              rst      = 1'b1;
  logic              hsel     = 1'b0;
  tmr_pkg::ahb_req_s req      = '0;
  logic [31:0]       hwdata   = '0;
  logic              hready;
  logic              hresp;
  logic [31:0]       hrdata;
  logic [2:0][7:0]   chan_ev  = '0;
  logic [5:0]        src_q    = '0;
  logic [2:0][2:0]   clk_sel  = '0;
  logic              slow_osc = 1'b0;
  logic [2:0]        sw_trig;
  logic [2:0]        tick;
  logic [2:0]        chan_irq;
  logic              irq;
  logic              cnt_clr  = 1'b0;
  int                tick_cnt [3];
  int                failures = 0;
  int                cmp_count = 0;
  logic [31:0]       rnd      = 32'h7954;
  logic [31:0]       rd;
  logic [7:0]        m;
  logic [7:0]        ev;
  logic [31:0]       wd;
  int                idx;

  timer_block_control_regs #(.NUM_CH(3), .VERSION_NUM(VER_NUM), .VARIANT_NUM(VAR_NUM)) dut_u (
    .sys_clk_i(sys_clk), .rst_i(rst), .hsel_i(hsel), .ahb_req_i(req), .hwdata_i(hwdata),
    .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
    .chan_event_i(chan_ev), .chan_out_a_i(src_q[5:3]), .chan_clk_sel_i(clk_sel),
    .pin_clk_i(src_q[2:0]), .slow_osc_i(slow_osc), .sw_trigger_o(sw_trig),
    .chan_tick_o(tick), .chan_irq_o(chan_irq), .irq_o(irq));

  // ----------------------------------------------------------------
  // clock, slow oscillator and tick counters
  // ----------------------------------------------------------------
  always #10 sys_clk = ~sys_clk;
  // period of 32 bus cycles, so a 256-cycle window always holds 8 rising edges
  always
  begin
    repeat (16) @(posedge sys_clk);
    slow_osc <= ~slow_osc;
  end
  always @(posedge sys_clk)
    for (int i = 0; i < 3; i++) tick_cnt[i] <= cnt_clr ? 0 : tick_cnt[i] + int'(tick[i]);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  // index into {out_a[2:0], pin[2:0]}, -1 when the line is left unconnected
  function automatic int route_src(input int l, input int v);
    if (v == 0) return l;
    if (v == 1) return -1;
    if (v == 2) return (l == 0) ? 4 : 3;
    return (l == 2) ? 4 : 5;
  endfunction : route_src
  function automatic int exp_ticks(input int s);
    return (s == 0) ? 8 : (256 >> (2 * s - 1));
  endfunction : exp_ticks
  function automatic logic [7:0] addr(input int c, input logic [7:0] off);
    return off + 8'(c) * tmr_pkg::CH_STRIDE;
  endfunction : addr
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results
  // one single transfer: address phase held until hready, then data phase held until hready
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] dout);
    hsel <= 1'b1;
    req.haddr <= {24'h000000, a};
    req.hwrite <= wr;
    req.htrans <= tmr_pkg::HTRANS_NONSEQ;
    req.hsize <= 3'h2;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    req.htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    do @(posedge sys_clk); while (hready !== 1'b1);
    dout = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr
  task automatic pulse(input int c, input logic [7:0] v);
    chan_ev[c] <= v;
    @(posedge sys_clk);
    chan_ev[c] <= 8'h00;
    @(posedge sys_clk);
  endtask : pulse

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    for (int c = 0; c < 3; c++)
    begin
      bus(1'b0, addr(c, tmr_pkg::OFF_MASK), 32'h0, rd);
      chk("mask reset", rd, 32'h0);
    end
    bus(1'b0, tmr_pkg::OFF_ROUTE, 32'h0, rd);
    chk("route reset", rd, 32'h0);
    wr(tmr_pkg::OFF_FEAT, 32'hFFFFFFFF);
    bus(1'b0, tmr_pkg::OFF_FEAT, 32'h0, rd);
    chk("features", rd, 32'h00000310);
    chk("bridge flag", {31'h0, rd[9]}, 32'h1);
    chk("counter width", {24'h0, rd[7:0]}, 32'h10);
    bus(1'b0, tmr_pkg::OFF_VER, 32'h0, rd);
    chk("revision", rd, {12'h000, VAR_NUM, 4'h0, VER_NUM});
    bus(1'b0, 8'hE0, 32'h0, rd);
    chk("unmapped", rd, 32'h0);
    // masks, sticky status and interrupts, random values per channel
    for (int c = 0; c < 3; c++)
    begin
      rnd = nxt(nxt(rnd));
      wr(addr(c, tmr_pkg::OFF_IEN), {24'h0, rnd[7:0] | 8'h01});
      bus(1'b0, addr(c, tmr_pkg::OFF_MASK), 32'h0, rd);
      chk("mask set", rd, {24'h0, rnd[7:0] | 8'h01});
      m = (rnd[7:0] | 8'h01) & ~(rnd[15:8] & 8'hFE);
      wr(addr(c, tmr_pkg::OFF_IDIS), {24'h0, rnd[15:8] & 8'hFE});
      wr(addr(c, tmr_pkg::OFF_MASK), 32'h000000FF);
      bus(1'b0, addr(c, tmr_pkg::OFF_MASK), 32'h0, rd);
      chk("mask clear", rd, {24'h0, m});
      ev = ~m;
      pulse(c, ev);
      @(posedge sys_clk);
      #1 chk("masked out", {29'h0, chan_irq}, 32'h0);
      @(posedge sys_clk);
      bus(1'b0, addr(c, tmr_pkg::OFF_STATUS), 32'h0, rd);
      chk("status", rd, {24'h0, ev});
      ev = rnd[23:16] | 8'h01;
      pulse(c, ev);
      @(posedge sys_clk);
      #1 chk("chan irq", {29'h0, chan_irq}, 32'h1 << c);
      chk("irq", {31'h0, irq}, 32'h1);
      @(posedge sys_clk);
      bus(1'b0, addr(c, tmr_pkg::OFF_STATUS), 32'h0, rd);
      chk("status", rd, {24'h0, ev});
      @(posedge sys_clk);
      #1 chk("irq cleared", {28'h0, chan_irq, irq}, 32'h0);
      @(posedge sys_clk);
      bus(1'b0, addr(c, tmr_pkg::OFF_STATUS), 32'h0, rd);
      chk("status cleared", rd, 32'h0);
      wr(addr(c, tmr_pkg::OFF_IDIS), 32'h000000FF);
    end
    // block command
    wr(tmr_pkg::OFF_CMD, 32'hFFFFFFFE);
    #1 chk("no trigger", {29'h0, sw_trig}, 32'h0);
    @(posedge sys_clk);
    wr(tmr_pkg::OFF_CMD, 32'h00000001);
    #1 chk("trigger", {29'h0, sw_trig}, 32'h7);
    @(posedge sys_clk);
    #1 chk("trigger pulse", {29'h0, sw_trig}, 32'h0);
    @(posedge sys_clk);
    // external clock line routing, every selector value of every line
    for (int l = 0; l < 3; l++)
      for (int v = 0; v < 4; v++)
      begin
        wd = (32'h15 & ~(32'h3 << (2 * l))) | (32'(v) << (2 * l));
        wr(tmr_pkg::OFF_ROUTE, wd);
        bus(1'b0, tmr_pkg::OFF_ROUTE, 32'h0, rd);
        chk("route", rd, wd);
        idx = route_src(l, v);
        clk_sel[0] <= 3'(5 + l);
        repeat (8) @(posedge sys_clk);
        cnt_clr <= 1'b1;
        @(posedge sys_clk);
        cnt_clr <= 1'b0;
        for (int k = 0; k < 4; k++)
        begin
          src_q <= (idx < 0) ? 6'h3F : 6'(1 << idx);
          repeat (8) @(posedge sys_clk);
          src_q <= 6'h00;
          repeat (8) @(posedge sys_clk);
        end
        repeat (8) @(posedge sys_clk);
        #1 chk("line ticks", tick_cnt[0], (idx < 0) ? 0 : 4);
        @(posedge sys_clk);
      end
    // internal sources, each channel on a different one at once
    for (int s = 0; s < 5; s++)
    begin
      for (int i = 0; i < 3; i++) clk_sel[i] <= 3'((s + i) % 5);
      repeat (8) @(posedge sys_clk);
      cnt_clr <= 1'b1;
      @(posedge sys_clk);
      cnt_clr <= 1'b0;
      repeat (256) @(posedge sys_clk);
      #1;
      for (int i = 0; i < 3; i++) chk("source ticks", tick_cnt[i], exp_ticks((s + i) % 5));
      @(posedge sys_clk);
    end
    // second reset in mid-run
    wr(tmr_pkg::OFF_IEN, 32'h000000FF);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    bus(1'b0, tmr_pkg::OFF_MASK, 32'h0, rd);
    chk("mask after reset", rd, 32'h0);
    results();
  end

  // a hang costs a mismatch and ends the run through the same verdict
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    results();
  end
endmodule : tb_timer_block_control_regs
`default_nettype wire
